// file: pkg/sdie_cfg.svh
// Offsets, field positions, reset values and timing counts of the speed drive block
`ifndef SDIE_CFG_SVH
`define SDIE_CFG_SVH
`define SDIE_OFF_CTRL      8'h00
`define SDIE_OFF_MAXSPD    8'h04
`define SDIE_OFF_PPR       8'h08
`define SDIE_OFF_ACCEL     8'h0c
`define SDIE_OFF_DECEL     8'h10
`define SDIE_OFF_INMAP     8'h14
`define SDIE_OFF_OUTMAP    8'h18
`define SDIE_OFF_STATUS    8'h1c
`define SDIE_OFF_POS       8'h20
`define SDIE_CTRL_ADV      0
`define SDIE_CTRL_STOPRAMP 1
`define SDIE_CTRL_PHREQ    2
`define SDIE_RST_CTRL      3'h4
`define SDIE_RST_MAXSPD    15'h0bb8
`define SDIE_RST_PPR       15'h0400
`define SDIE_RST_ACCEL     16'h000a
`define SDIE_RST_DECEL     16'h000a
`define SDIE_RST_INMAP     12'h8d1
`define SDIE_RST_OUTMAP    9'h088
`define SDIE_MAXSPD_MIN    15'h0064
`define SDIE_MAXSPD_MAX    15'h61a8
`define SDIE_PPR_MIN       15'h0040
`define SDIE_PPR_MAX       15'h4000
`define SDIE_CLK_HZ        25000000
`define SDIE_RAMP_TICK_US  1000
`define SDIE_RAMP_TICK_CYC (`SDIE_RAMP_TICK_US * (`SDIE_CLK_HZ / 1000000))
`define SDIE_ENC_MOD       (60 * `SDIE_CLK_HZ)
`define SDIE_ILIM_FULL     12'hfff
`endif

// file: pkg/sdie_pkg.sv
// Types shared by the speed drive block
package sdie_pkg;
  typedef struct packed {
    logic       enable;
    logic       lim_pos;
    logic       lim_neg;
    logic       stop;
    logic       fault_rst;
    logic       phase;
    logic       power_ok;
    logic [3:0] cfg_in;
  } sdie_pins_t;
  typedef struct packed {
    logic warning;
    logic fault;
    logic phasing_needed;
    logic power;
    logic drive_on;
    logic brake;
  } sdie_status_t;
  typedef enum logic [2:0] {
    SDIE_IN_NONE, SDIE_IN_LIMP, SDIE_IN_LIMN, SDIE_IN_STOP, SDIE_IN_RST, SDIE_IN_PHASE
  } sdie_in_fn_t;
endpackage : sdie_pkg

// file: src/sdie_top.sv
// Speed drive control: command scaling, ramps, I/O functions and encoder emulation
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "sdie_cfg.svh"

//Contract
// RULE_01 - Emit position as quadrature channels A, B plus one marker per revolution.
// RULE_02 - Accept any emulation resolution from 64 to 16384 pulses per revolution.
// RULE_03 - Full-scale command maps to programmable maximum speed, 100 to 25000 rpm.
// RULE_04 - Controller drives enable; motor energised while active, off when inactive.
// RULE_05 - Limit speed reference slew with separate acceleration and deceleration settings.
// RULE_06 - Positive limit blocks clockwise, negative limit blocks counter-clockwise rotation.
// RULE_07 - Stop input brings axis to rest at current limit or by ramp.
// RULE_08 - Reset input clears latched fault only after its cause has gone.
// RULE_09 - Brake output follows drive enabling and disabling.
// RULE_10 - Drive-active output asserted while drive is enabled.
// RULE_11 - Power-present output asserted while supply voltage is detected.
// RULE_12 - Peak current limit proportional to limit input; zero input means unlimited.
// RULE_13 - Advanced variant assigns four inputs to limit, stop, reset or phasing.
// RULE_14 - Phasing input starts the motor phasing procedure.
// RULE_15 - Advanced variant assigns three outputs to any of six status functions.
// RULE_16 - Phasing-needed output asserted while phasing is still required.
// RULE_17 - Fault and warning outputs follow present fault and warning.
// RULE_18 - Channel A leads B clockwise and lags B counter-clockwise.
// RULE_19 - Marker is one quadrature state wide at emulated zero position.
// RULE_20 - Latched fault keeps brake engaged and drive-active deasserted.
module sdie_top #(
  parameter int RAMP_TICK_CYC = `SDIE_RAMP_TICK_CYC
) (
  input  wire logic                clk_sys_i,       // System clock
  input  wire logic                sys_rst_i,       // Synchronous reset
  input  wire sdie_pkg::sdie_pins_t pins_i,         // Asynchronous logic inputs
  input  wire logic signed [15:0]  speed_command_input_i, // Sampled speed command
  input  wire logic [11:0]         ilim_i,          // Sampled current-limit input
  input  wire logic                fault_cond_i,    // Fault cause present
  input  wire logic                warn_cond_i,     // Warning present
  input  wire logic                phasing_done_i,  // Phasing procedure finished
  output logic signed [15:0]       speed_ref_o,     // Ramped speed reference, rpm
  output logic [11:0]              cur_limit_o,     // Peak current limit fraction
  output logic                     motor_on_o,      // Power stage energised
  output logic                     phasing_start_o, // Start phasing pulse
  output logic                     enc_a_o,         // Encoder channel A
  output logic                     enc_b_o,         // Encoder channel B
  output logic                     enc_z_o,         // Encoder marker
  output sdie_pkg::sdie_status_t   status_o,        // Dedicated status outputs
  output logic                     config_output_one_o,   // Assignable output 1
  output logic                     config_output_two_o,   // Assignable output 2
  output logic                     config_output_three_o, // Assignable output 3
  input  wire logic [7:0]          s_axi_awaddr,    // Write address
  input  wire logic                s_axi_awvalid,   // Write address valid
  output logic                     s_axi_awready,   // Write address ready
  input  wire logic [31:0]         s_axi_wdata,     // Write data
  input  wire logic [3:0]          s_axi_wstrb,     // Write strobes
  input  wire logic                s_axi_wvalid,    // Write data valid
  output logic                     s_axi_wready,    // Write data ready
  output logic [1:0]               s_axi_bresp,     // Write response
  output logic                     s_axi_bvalid,    // Write response valid
  input  wire logic                s_axi_bready,    // Write response ready
  input  wire logic [7:0]          s_axi_araddr,    // Read address
  input  wire logic                s_axi_arvalid,   // Read address valid
  output logic                     s_axi_arready,   // Read address ready
  output logic [31:0]              s_axi_rdata,     // Read data
  output logic [1:0]               s_axi_rresp,     // Read response
  output logic                     s_axi_rvalid,    // Read data valid
  input  wire logic                s_axi_rready     // Read data ready
);
  import sdie_pkg::*;

  // ----------
  // Declarations
  // ----------
  sdie_pins_t        sync1_q, sync2_q;
  logic [2:0]        ctrl_q;
  logic [14:0]       maxspd_q, ppr_q;
  logic [15:0]       accel_q, decel_q;
  logic [11:0]       inmap_q;
  logic [8:0]        outmap_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_full_q, w_full_q;
  logic              fault_q, rst_in_q, ph_in_q, ph_need_q;
  logic signed [15:0] ref_q;
  logic [15:0]       pos_q;
  logic [1:0]        quad_q;
  logic [32:0]       acc_q;
  logic [31:0]       tick_cnt_q;
  logic              tick;
  logic [5:0]        fn_in;
  logic [5:0]        hit [4];
  logic              lim_p, lim_n, stop_a, frst_a, phase_a, run;
  logic signed [31:0] scaled;
  logic signed [15:0] tgt;
  logic signed [16:0] diff;
  logic [15:0]       step;
  logic              growing;
  logic [31:0]       inc;
  logic [32:0]       acc_n;
  logic [15:0]       pos_top;
  logic              dir_cw;
  logic [5:0]        out_fn;
  logic [31:0]       rd_val;
  logic              rd_ok;

  // ----------
  // Pin synchronisers
  // ----------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_i;
      sync2_q <= sync1_q;
    end
  end

  // ----------
  // Input function assignment
  // ----------
  for (genvar i = 0; i < 4; i++) begin : g_inmap
    always_comb begin
      hit[i] = '0;
      hit[i][inmap_q[3*i +: 3]] = sync2_q.cfg_in[i]; // see RULE_13
    end
  end

  always_comb begin
    fn_in = hit[0] | hit[1] | hit[2] | hit[3];
    if (ctrl_q[`SDIE_CTRL_ADV]) begin
      lim_p   = fn_in[SDIE_IN_LIMP]; // see RULE_13
      lim_n   = fn_in[SDIE_IN_LIMN];
      stop_a  = fn_in[SDIE_IN_STOP];
      frst_a  = fn_in[SDIE_IN_RST];
      phase_a = fn_in[SDIE_IN_PHASE];
    end else begin
      lim_p   = sync2_q.lim_pos;
      lim_n   = sync2_q.lim_neg;
      stop_a  = sync2_q.stop;
      frst_a  = sync2_q.fault_rst;
      phase_a = sync2_q.phase;
    end
  end

  // ----------
  // Fault latch, enabling and phasing
  // ----------
  // Power stage runs only with enable, supply present and no latched fault
  assign run = sync2_q.enable & sync2_q.power_ok & ~fault_q; // see RULE_04 see RULE_20

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fault_q  <= 1'b0;
      rst_in_q <= 1'b0;
    end else begin
      rst_in_q <= frst_a;
      // New fault wins over a reset edge in the same cycle
      if (fault_cond_i)
        fault_q <= 1'b1;
      else if (frst_a & ~rst_in_q)
        fault_q <= 1'b0; // see RULE_08
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ph_in_q         <= 1'b0;
      ph_need_q       <= 1'b0;
      phasing_start_o <= 1'b0;
    end else begin
      ph_in_q         <= phase_a;
      phasing_start_o <= phase_a & ~ph_in_q & ph_need_q & run; // see RULE_14
      if (phasing_done_i)
        ph_need_q <= 1'b0;
      else if (ctrl_q[`SDIE_CTRL_PHREQ] & ~sync2_q.power_ok)
        ph_need_q <= 1'b1; // see RULE_16
    end
  end

  // ----------
  // Status outputs
  // ----------
  always_comb begin
    out_fn = {warn_cond_i, fault_q, ph_need_q, sync2_q.power_ok, run, ~run};
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status_o   <= '0;
      motor_on_o <= 1'b0;
    end else begin
      motor_on_o              <= run; // see RULE_04
      status_o.brake          <= ~run; // see RULE_09 see RULE_20
      status_o.drive_on       <= run; // see RULE_10
      status_o.power          <= sync2_q.power_ok; // see RULE_11
      status_o.phasing_needed <= ph_need_q; // see RULE_16
      status_o.fault          <= fault_q; // see RULE_17
      status_o.warning        <= warn_cond_i; // see RULE_17
    end
  end

  logic [2:0] cfg_out_q;
  for (genvar o = 0; o < 3; o++) begin : g_outmap
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i)
        cfg_out_q[o] <= 1'b0;
      else if (outmap_q[3*o +: 3] < 3'h6)
        cfg_out_q[o] <= out_fn[outmap_q[3*o +: 3]]; // see RULE_15
      else
        cfg_out_q[o] <= 1'b0;
    end
  end
  assign config_output_one_o   = cfg_out_q[0];
  assign config_output_two_o   = cfg_out_q[1];
  assign config_output_three_o = cfg_out_q[2];

  // ----------
  // Current limit
  // ----------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i)
      cur_limit_o <= `SDIE_ILIM_FULL;
    else
      cur_limit_o <= (ilim_i == 12'h000) ? `SDIE_ILIM_FULL : ilim_i; // see RULE_12
  end

  // ----------
  // Command scaling and ramp
  // ----------
  always_comb begin
    scaled = 32'(speed_command_input_i) * 32'($signed({1'b0, maxspd_q})); // see RULE_03
    tgt    = 16'(scaled >>> 15);
    if ((lim_p && tgt > 16'sh0000) || (lim_n && tgt < 16'sh0000) || stop_a || !run)
      tgt = 16'sh0000; // see RULE_06 see RULE_07
    diff    = 17'(tgt) - 17'(ref_q);
    growing = (diff > 0 && ref_q >= 0) || (diff < 0 && ref_q <= 0);
    step    = growing ? accel_q : decel_q; // see RULE_05
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end
  assign tick = (tick_cnt_q >= 32'(RAMP_TICK_CYC - 1));

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ref_q <= '0;
    end else if (!run || (stop_a && !ctrl_q[`SDIE_CTRL_STOPRAMP])) begin
      ref_q <= '0; // see RULE_04 see RULE_07
    end else if (tick) begin
      if ((diff >= 0 ? diff : -diff) <= $signed({1'b0, step}))
        ref_q <= tgt;
      else if (diff > 0)
        ref_q <= 16'(ref_q + $signed({1'b0, step})); // see RULE_05
      else
        ref_q <= 16'(ref_q - $signed({1'b0, step}));
    end
  end
  assign speed_ref_o = ref_q;

  // ----------
  // Encoder emulation
  // ----------
  // At most one quadrature state per clock; higher rates saturate
  always_comb begin
    dir_cw  = ~ref_q[15];
    inc     = 32'(ref_q[15] ? -ref_q : ref_q) * 32'({ppr_q, 2'b00});
    acc_n   = acc_q + 33'(inc);
    pos_top = 16'({ppr_q, 2'b00} - 17'h1); // see RULE_02
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      acc_q  <= '0;
      pos_q  <= '0;
      quad_q <= 2'b00;
    end else if (acc_n >= 33'(`SDIE_ENC_MOD)) begin
      acc_q <= (acc_n - 33'(`SDIE_ENC_MOD) >= 33'(`SDIE_ENC_MOD)) ?
               33'(`SDIE_ENC_MOD) - 33'h1 : acc_n - 33'(`SDIE_ENC_MOD);
      if (dir_cw) begin
        pos_q  <= (pos_q >= pos_top) ? 16'h0000 : pos_q + 16'h1;
        quad_q <= {~quad_q[0], quad_q[1]}; // see RULE_18
      end else begin
        pos_q  <= (pos_q == 16'h0000) ? pos_top : pos_q - 16'h1;
        quad_q <= {quad_q[0], ~quad_q[1]};
      end
    end else begin
      acc_q <= acc_n;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      enc_a_o <= 1'b0;
      enc_b_o <= 1'b0;
      enc_z_o <= 1'b0;
    end else begin
      enc_a_o <= quad_q[1]; // see RULE_01
      enc_b_o <= quad_q[0];
      enc_z_o <= (pos_q == 16'h0000); // see RULE_19
    end
  end

  // ----------
  // AXI4-Lite write path
  // ----------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : merge

  function automatic logic [14:0] clamp(input logic [31:0] v, input logic [14:0] lo,
                                        input logic [14:0] hi);
    if (v < 32'(lo))
      return lo;
    if (v > 32'(hi))
      return hi;
    return v[14:0];
  endfunction : clamp

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      ctrl_q        <= `SDIE_RST_CTRL;
      maxspd_q      <= `SDIE_RST_MAXSPD;
      ppr_q         <= `SDIE_RST_PPR;
      accel_q       <= `SDIE_RST_ACCEL;
      decel_q       <= `SDIE_RST_DECEL;
      inmap_q       <= `SDIE_RST_INMAP;
      outmap_q      <= `SDIE_RST_OUTMAP;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full_q && w_full_q && !s_axi_bvalid) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case ({awaddr_q[7:2], 2'b00})
          `SDIE_OFF_CTRL:   ctrl_q   <= 3'(merge(32'(ctrl_q), wdata_q, wstrb_q));
          `SDIE_OFF_MAXSPD: maxspd_q <= clamp(merge(32'(maxspd_q), wdata_q, wstrb_q),
                                              `SDIE_MAXSPD_MIN, `SDIE_MAXSPD_MAX); // see RULE_03
          `SDIE_OFF_PPR:    ppr_q    <= clamp(merge(32'(ppr_q), wdata_q, wstrb_q),
                                              `SDIE_PPR_MIN, `SDIE_PPR_MAX); // see RULE_02
          `SDIE_OFF_ACCEL:  accel_q  <= 16'(merge(32'(accel_q), wdata_q, wstrb_q));
          `SDIE_OFF_DECEL:  decel_q  <= 16'(merge(32'(decel_q), wdata_q, wstrb_q));
          `SDIE_OFF_INMAP:  inmap_q  <= 12'(merge(32'(inmap_q), wdata_q, wstrb_q));
          `SDIE_OFF_OUTMAP: outmap_q <= 9'(merge(32'(outmap_q), wdata_q, wstrb_q));
          `SDIE_OFF_STATUS, `SDIE_OFF_POS: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------
  // AXI4-Lite read path
  // ----------
  always_comb begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `SDIE_OFF_CTRL:   rd_val = 32'(ctrl_q);
      `SDIE_OFF_MAXSPD: rd_val = 32'(maxspd_q);
      `SDIE_OFF_PPR:    rd_val = 32'(ppr_q);
      `SDIE_OFF_ACCEL:  rd_val = 32'(accel_q);
      `SDIE_OFF_DECEL:  rd_val = 32'(decel_q);
      `SDIE_OFF_INMAP:  rd_val = 32'(inmap_q);
      `SDIE_OFF_OUTMAP: rd_val = 32'(outmap_q);
      `SDIE_OFF_STATUS: rd_val = 32'({ph_in_q, stop_a, lim_n, lim_p, status_o});
      `SDIE_OFF_POS:    rd_val = {ref_q, pos_q};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sdie_top

// file: testbench/sdie_ctl_model.sv
// Motion controller model: drives the enable line and counts encoder feedback
`timescale 1ns/1ns
module sdie_ctl_model (
  input  wire logic          clk_sys_i, // System clock
  input  wire logic          sys_rst_i, // Synchronous reset
  input  wire logic          en_req_i,  // Enable request
  input  wire logic          enc_a_i,   // Channel A
  input  wire logic          enc_b_i,   // Channel B
  output logic               enable_o,  // Enable line
  output logic signed [31:0] pos_o      // Decoded position
);
  logic a_q, b_q;
  always_ff @(posedge clk_sys_i) enable_o <= en_req_i;
  always_ff @(posedge clk_sys_i) a_q <= enc_a_i;
  always_ff @(posedge clk_sys_i) b_q <= enc_b_i;
  // Counts up when A leads, down when it lags
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) pos_o <= '0;
    else if (enc_a_i != a_q) pos_o <= pos_o + ((enc_a_i != enc_b_i) ? 1 : -1);
    else if (enc_b_i != b_q) pos_o <= pos_o + ((enc_b_i == enc_a_i) ? 1 : -1);
  end
endmodule : sdie_ctl_model

// file: testbench/sdie_props.sv
// Concurrent checks on the ports of the speed drive block
`timescale 1ns/1ns
module sdie_props #(
  parameter int RAMP_TICK_CYC = 10
) (
  input wire logic                   clk_sys_i,    // System clock
  input wire logic                   sys_rst_i,    // Synchronous reset
  input wire sdie_pkg::sdie_pins_t   pins_i,       // Logic inputs
  input wire logic [11:0]            ilim_i,       // Current-limit input
  input wire logic                   fault_cond_i, // Fault cause
  input wire logic [11:0]            cur_limit_o,  // Current limit
  input wire logic                   motor_on_o,   // Power stage on
  input wire logic                   enc_a_o,      // Channel A
  input wire logic                   enc_b_o,      // Channel B
  input wire sdie_pkg::sdie_status_t status_o,     // Status outputs
  input wire logic signed [15:0]     speed_ref_o   // Speed reference
);
  import sdie_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  // Sign settled over two samples
  sequence s_cw;
    $past(speed_ref_o) > 0 && $past(speed_ref_o, 2) > 0;
  endsequence
  sequence s_pw;
    pins_i.power_ok [*5];
  endsequence
  sequence s_flt;
    fault_cond_i [*4];
  endsequence
  AST_ILIM_ZERO: assert property (ilim_i == 12'h000 |=> cur_limit_o == 12'hfff)
    else $error("zero limit input not unlimited");
  AST_ILIM_PROP: assert property (ilim_i != 12'h000 |=> cur_limit_o == $past(ilim_i))
    else $error("current limit not proportional");
  AST_MOTOR_OFF: assert property (!pins_i.enable |-> ##3 !motor_on_o)
    else $error("motor on without enable");
  AST_BRAKE: assert property (!$past(sys_rst_i) |-> status_o.brake != motor_on_o)
    else $error("brake not following drive state");
  AST_DRIVE_ON: assert property (status_o.drive_on == motor_on_o)
    else $error("drive-on status differs from drive state");
  AST_POWER: assert property (s_pw |-> status_o.power)
    else $error("power status missing");
  AST_FAULT_OUT: assert property (fault_cond_i |-> ##[1:2] status_o.fault)
    else $error("fault status missing");
  AST_FAULT_HOLD: assert property (s_flt |-> status_o.brake && !status_o.drive_on)
    else $error("drive active under fault");
  AST_QUAD: assert property (!($changed(enc_a_o) && $changed(enc_b_o)))
    else $error("both channels changed at once");
  AST_CW_DIR: assert property (s_cw ##0 $changed(enc_a_o) |-> enc_a_o != $past(enc_b_o))
    else $error("channel A not leading clockwise");
endmodule : sdie_props
bind sdie_top sdie_props #(.RAMP_TICK_CYC(RAMP_TICK_CYC)) sdie_props_inst (.clk_sys_i, .sys_rst_i,
  .pins_i, .ilim_i, .fault_cond_i, .cur_limit_o, .motor_on_o, .enc_a_o, .enc_b_o, .status_o,
  .speed_ref_o);

// file: testbench/speed_drive_io_encoder_emulation_tb.sv
// Self-checking bench for the speed drive block
`timescale 1ns/1ns
module speed_drive_io_encoder_emulation_tb;
  import sdie_pkg::*;
  logic               clk_sys_i = 0, sys_rst_i = 1, en_req = 0, en;
  sdie_pins_t         p = '0, pins;
  logic signed [15:0] speed_command_input_i = 0, speed_ref_o;
  logic [11:0]        ilim_i = 0, cur_limit_o;
  logic               fault_cond_i = 0, warn_cond_i = 0, phasing_done_i = 0;
  logic               motor_on_o, phasing_start_o, enc_a_o, enc_b_o, enc_z_o;
  sdie_status_t       status_o;
  logic               config_output_one_o;
  logic [7:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]        s_axi_wdata = 0, s_axi_rdata, q;
  logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic               s_axi_bready = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic               s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, r;
  logic signed [31:0] pos;
  int                 failures = 0, n_compared = 0, i, c, c0;
  logic [7:0]         ta [5] = '{8'h08, 8'h08, 8'h08, 8'h04, 8'h04};
  int                 td [5] = '{16385, 1000, 63, 99, 25001};
  int                 te [5] = '{16384, 1000, 64, 100, 25000};
  logic [5:0]         st = 6'b000110;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  always_comb begin
    pins = p;
    pins.enable = en;
  end
  sdie_top #(.RAMP_TICK_CYC(10)) sdie_top_inst (.clk_sys_i, .sys_rst_i, .pins_i(pins),
    .speed_command_input_i, .ilim_i, .fault_cond_i, .warn_cond_i, .phasing_done_i,
    .speed_ref_o, .cur_limit_o, .motor_on_o, .phasing_start_o, .enc_a_o, .enc_b_o, .enc_z_o,
    .status_o, .config_output_one_o, .config_output_two_o(), .config_output_three_o(),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sdie_ctl_model sdie_ctl_model_inst (.clk_sys_i, .sys_rst_i, .en_req_i(en_req),
    .enc_a_i(enc_a_o), .enc_b_i(enc_b_o), .enable_o(en), .pos_o(pos));
  function automatic logic [15:0] tgt(input int cmd, input int m);
    return 16'((cmd * m) >>> 15);
  endfunction : tgt
  function automatic logic [11:0] exp_lim(input logic [11:0] v);
    return (v == 12'h000) ? 12'hfff : v;
  endfunction : exp_lim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic summarize;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    if (n == 100) failures++;
    s_axi_bready <= 0;
    s_axi_rready <= 0;
  endtask : bus
  task automatic wait_ref(input logic signed [15:0] v);
    @(negedge clk_sys_i);
    for (c = 0; c < 4000 && speed_ref_o !== v; c++)
      @(negedge clk_sys_i);
    chk(speed_ref_o, v);
  endtask : wait_ref
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    failures++;
    summarize();
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    void'($urandom(32'h9794));
    cyc(16);
    sys_rst_i <= 0;
    cyc(2);
    @(negedge clk_sys_i);
    chk({status_o.phasing_needed, status_o.brake}, 2'b11);
    bus(0, 8'h08, 0);
    chk(q, 32'h400);
    bus(0, 8'h04, 0);
    chk(q, 32'hbb8);
    bus(0, 8'h3c, 0);
    chk(r, 2'b10);
    for (i = 0; i < 5; i++) begin
      bus(1, ta[i], td[i]);
      bus(0, ta[i], 0);
      chk(q, te[i]);
    end
    bus(1, 8'h0c, 1000);
    bus(1, 8'h10, 1000);
    repeat (20) begin
      cyc(1);
      ilim_i <= ($urandom % 3 == 0) ? 12'h000 : 12'($urandom);
      cyc(1);
      @(negedge clk_sys_i);
      chk(cur_limit_o, exp_lim(ilim_i));
    end
    cyc(1);
    p.power_ok <= 1;
    en_req <= 1;
    cyc(6);
    @(negedge clk_sys_i);
    chk({motor_on_o, status_o.drive_on, status_o.brake, status_o.power}, 4'b1101);
    cyc(1);
    p.phase <= 1;
    for (c = 0; c < 8 && phasing_start_o !== 1'b1; c++)
      @(negedge clk_sys_i);
    chk(phasing_start_o, 1);
    cyc(1);
    p.phase <= 0;
    phasing_done_i <= 1;
    cyc(1);
    phasing_done_i <= 0;
    cyc(3);
    @(negedge clk_sys_i);
    chk({status_o.phasing_needed, enc_z_o, enc_a_o, enc_b_o}, 4'b0100);
    cyc(1);
    speed_command_input_i <= 16'sh7fff;
    wait_ref(tgt(32767, 25000));
    chk(c >= 230, 1);
    cyc(3000);
    @(negedge clk_sys_i);
    chk({pos > 8, enc_z_o}, 2'b10);
    cyc(1);
    p.lim_pos <= 1;
    wait_ref(0);
    cyc(1);
    p.lim_pos <= 0;
    speed_command_input_i <= 16'sh8000;
    wait_ref(tgt(-32768, 25000));
    c0 = pos;
    cyc(4000);
    @(negedge clk_sys_i);
    chk(pos < c0 - 8, 1);
    cyc(1);
    p.lim_neg <= 1;
    wait_ref(0);
    cyc(1);
    p.lim_neg <= 0;
    wait_ref(-25000);
    cyc(1);
    p.stop <= 1;
    wait_ref(0);
    chk(c <= 5, 1);
    cyc(1);
    p.stop <= 0;
    bus(1, 8'h00, 6);
    wait_ref(-25000);
    cyc(1);
    p.stop <= 1;
    wait_ref(0);
    chk(c >= 200, 1);
    cyc(1);
    p.stop <= 0;
    bus(1, 8'h00, 1);
    wait_ref(-25000);
    cyc(1);
    p.cfg_in <= 4'h4;
    wait_ref(0);
    chk(c <= 5, 1);
    for (i = 0; i < 8; i++) begin
      bus(1, 8'h18, i);
      cyc(3);
      @(negedge clk_sys_i);
      chk(config_output_one_o, (i < 6) ? st[i] : 1'b0);
    end
    cyc(1);
    p.cfg_in <= 4'h0;
    bus(1, 8'h00, 0);
    fault_cond_i <= 1;
    warn_cond_i <= 1;
    cyc(4);
    p.fault_rst <= 1;
    cyc(1);
    p.fault_rst <= 0;
    cyc(4);
    @(negedge clk_sys_i);
    chk({status_o.fault, status_o.warning, status_o.brake, motor_on_o}, 4'b1110);
    cyc(1);
    fault_cond_i <= 0;
    warn_cond_i <= 0;
    cyc(4);
    @(negedge clk_sys_i);
    chk({status_o.fault, status_o.warning}, 2'b10);
    cyc(1);
    p.fault_rst <= 1;
    cyc(1);
    p.fault_rst <= 0;
    cyc(6);
    @(negedge clk_sys_i);
    chk({status_o.fault, motor_on_o}, 2'b01);
    cyc(1);
    en_req <= 0;
    cyc(6);
    @(negedge clk_sys_i);
    chk({motor_on_o, status_o.brake, status_o.drive_on}, 3'b010);
    summarize();
  end
endmodule : speed_drive_io_encoder_emulation_tb
